// ===== design/seq_status_map.svh
// Purpose: offsets, bit positions and timing counts of the status bank
// Assumes: byte-wide registers on a plain port, index addressing
// Notes: definitions only
`ifndef SEQ_STATUS_MAP_SVH
`define SEQ_STATUS_MAP_SVH
`define ADDR_DMA_EXT_CTRL 8'h23
`define ADDR_SEQ_STATUS 8'h10
`define ADDR_EXT_STATUS 8'h11
`define ADDR_STATE_RETRY 8'h12
`define ADDR_ID_FIFTH 8'h13
`define ADDR_ID_HDR0 8'h14
`define ADDR_ID_HDR3 8'h17
`define ADDR_ID_HDR_BASE 8'h14
`define ADDR_DMA_BANK0 8'h40
`define ADDR_DMA_BANK1 8'h41
`define ADDR_CTRL_MISC 8'h42
`define BIT_BANK_CNT_CH0 3
`define BIT_BANK_CNT_CH1 7
`define BIT_PARITY_EN 4
`define BIT_DSYNC_TO_EN 7
`define BIT_DSYNC_SHORT 6
`define BIT_FLAG_BYTE_MODE 2
`define BIT_SEQ_INT_EN 7
`define SEQ_STATUS_PRESET 8'h71
`define SEQ_STATUS_PRESET_MASK 8'h7F
`define EXT_OR_MASK 8'h1F
`define DSYNC_LONG_BITS 16'h0200
`define DSYNC_SHORT_BITS 16'h0020
`define BYTE_TIME_BITS 16'h0008
`endif

// ===== design/seq_status_pkg.sv
// Purpose: shared types of the status bank
// Assumes: header holds all numbers
// Notes: none
package seq_status_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic busy;
        logic data_ecc_err;
        logic data_sync_err;
        logic verify_err;
        logic id_ecc_err;
        logic id_sync_err;
        logic id_match;
        logic id_mismatch;
        logic id_sync_ok;
        logic index_timeout;
        logic cmd_start;
        logic cmd_abort;
        logic cmd_verify;
        logic cmd_rw;
        logic cmd_read;
        logic data_sync_seen;
        logic wait_data_sync;
        logic id_byte_valid;
        logic [2:0] id_byte_idx;
        logic [7:0] id_byte;
        logic mem_parity_err;
    } seq_event_t;
endpackage

// ===== design/seq_status_regs.sv
// Purpose: status, readback and bank counters of the disk sequencer
// Assumes: sequencer events are synchronous to clock_i; disk pulses are not
// Notes: assertions inline; bit times counted by bit_tick_i
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "seq_status_map.svh"
module seq_status_regs (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire seq_status_pkg::seq_event_t ev_i,
    input wire logic [3:0] seq_state_i,
    input wire logic [3:0] retry_count_i,
    input wire logic bit_tick_i,
    input wire logic sector_pin_i,
    input wire logic index_pin_i,
    input wire logic chan0_dma_request_i,
    input wire logic chan0_dma_acknowledge_i,
    input wire logic port_access_i,
    input wire logic [15:0] ch0_addr_i,
    input wire logic [15:0] ch1_addr_i,
    output logic [3:0] ch0_bank_o,
    output logic [3:0] ch1_bank_o,
    output logic sequencer_interrupt_o
);
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    seq_status_pkg::reg_req_t req;
    logic [7:0] dma_ext_q, misc_q, seq_q, ext_q, fifth_q, rdata_q;
    logic [7:0] id_q [4];
    logic [3:0] bank0_q, bank1_q;
    logic [15:0] a0_q, a1_q;
    logic int_q, busy_q;
    logic [1:0] sec_s, idx_s;
    logic sec_d1, idx_d1;
    logic [15:0] dsync_cnt_q, ack_cnt_q;
    logic ack_wait_q, port_wait_q;
    logic parity_en, flag_byte_mode, int_en;
    logic cmd_preset, status_rd;
    logic [7:0] seq_rd;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    // misc ctrl: parity enable, sync timeout enable/length, flag mode, int
    assign parity_en = misc_q[`BIT_PARITY_EN];
    assign flag_byte_mode = misc_q[`BIT_FLAG_BYTE_MODE];
    assign int_en = misc_q[`BIT_SEQ_INT_EN];
    assign cmd_preset = ev_i.cmd_start && !ev_i.cmd_abort;
    assign status_rd = req.rd && req.addr == `ADDR_SEQ_STATUS;
    assign seq_rd = {|(ext_q & `EXT_OR_MASK), seq_q[6:0]};

    // write side: control registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dma_ext_q <= 8'h00;
            misc_q <= 8'h00;
        end else if (req.wr) begin
            if (req.addr == `ADDR_DMA_EXT_CTRL) begin
                dma_ext_q <= req.wdata & 8'hBB; // bits 2 and 6 reserved
            end
            if (req.addr == `ADDR_CTRL_MISC) begin
                misc_q <= req.wdata;
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `ADDR_SEQ_STATUS: rdata_q <= seq_rd;
                `ADDR_EXT_STATUS: rdata_q <= ext_q;
                `ADDR_STATE_RETRY: begin
                    rdata_q <= {seq_state_i, retry_count_i};
                end
                `ADDR_ID_FIFTH: rdata_q <= fifth_q;
                `ADDR_DMA_BANK0: rdata_q <= {4'h0, bank0_q};
                `ADDR_DMA_BANK1: rdata_q <= {4'h0, bank1_q};
                `ADDR_CTRL_MISC: rdata_q <= misc_q;
                default: begin
                    if (req.addr >= `ADDR_ID_HDR0 &&
                        req.addr <= `ADDR_ID_HDR3) begin
                        rdata_q <= id_q[req.addr[1:0]];
                    end else begin
                        rdata_q <= 8'h00;
                    end
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_o = rdata_q;
    // state nibble passes raw: the reader must debounce it

    // ------------------------------------------------------------------
    // bank counters
    // ------------------------------------------------------------------
    // wrap seen as previous FFFF and now 0000
    function automatic logic wrapped(input logic [15:0] prev,
                                     input logic [15:0] now);
        wrapped = prev == 16'hFFFF && now == 16'h0000;
    endfunction

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bank0_q <= 4'h0;
            bank1_q <= 4'h0;
            a0_q <= 16'h0000;
            a1_q <= 16'h0000;
        end else begin
            a0_q <= ch0_addr_i;
            a1_q <= ch1_addr_i;
            if (req.wr && req.addr == `ADDR_DMA_BANK0) begin
                bank0_q <= req.wdata[3:0];
            end else if (dma_ext_q[`BIT_BANK_CNT_CH0] &&
                         wrapped(a0_q, ch0_addr_i)) begin
                bank0_q <= bank0_q + 4'h1;
            end
            if (req.wr && req.addr == `ADDR_DMA_BANK1) begin
                bank1_q <= req.wdata[3:0];
            end else if (dma_ext_q[`BIT_BANK_CNT_CH1] &&
                         wrapped(a1_q, ch1_addr_i)) begin
                bank1_q <= bank1_q + 4'h1;
            end
        end
    end
    assign ch0_bank_o = bank0_q;
    assign ch1_bank_o = bank1_q;

    // ------------------------------------------------------------------
    // sequencer status
    // ------------------------------------------------------------------
    // events are applied after the preset so a same-cycle error survives
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_q <= 8'h00;
        end else begin
            if (cmd_preset) begin
                seq_q <= (seq_q & ~`SEQ_STATUS_PRESET_MASK) |
                         `SEQ_STATUS_PRESET;
            end
            seq_q[0] <= ev_i.busy || cmd_preset;
            if (ev_i.cmd_read && ev_i.data_ecc_err) begin
                seq_q[1] <= 1'b1;
            end
            if (ev_i.data_sync_err) begin
                seq_q[2] <= 1'b1;
            end
            if (ev_i.cmd_verify && (ev_i.data_ecc_err ||
                ev_i.data_sync_err || ev_i.id_ecc_err ||
                ev_i.id_sync_err || ev_i.id_mismatch)) begin
                seq_q[3] <= 1'b1;
            end
            if (ev_i.id_ecc_err) begin
                seq_q[4] <= 1'b1;
            end
            if (ev_i.cmd_rw && ev_i.id_sync_err) begin
                seq_q[5] <= 1'b1;
            end
            if (ev_i.id_mismatch) begin
                seq_q[6] <= 1'b1;
            end else if (ev_i.id_match) begin
                seq_q[6] <= 1'b0;
            end
        end
    end

    // interrupt on busy falling; the fall wins over a same-cycle read
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            busy_q <= seq_q[0];
            if (int_en && busy_q && !seq_q[0]) begin
                int_q <= 1'b1;
            end else if (status_rd) begin
                int_q <= 1'b0;
            end
        end
    end
    assign sequencer_interrupt_o = int_q;

    // ------------------------------------------------------------------
    // disk pulse synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_s <= 2'b00;
            idx_s <= 2'b00;
            sec_d1 <= 1'b0;
            idx_d1 <= 1'b0;
        end else begin
            sec_s <= {sec_s[0], sector_pin_i};
            idx_s <= {idx_s[0], index_pin_i};
            sec_d1 <= sec_s[1];
            idx_d1 <= idx_s[1];
        end
    end

    // ------------------------------------------------------------------
    // dma response watchdogs
    // ------------------------------------------------------------------
    // a request not acknowledged within one byte time of bit ticks
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_wait_q <= 1'b0;
            ack_cnt_q <= 16'h0000;
            port_wait_q <= 1'b0;
        end else begin
            if (chan0_dma_acknowledge_i || !chan0_dma_request_i) begin
                ack_wait_q <= 1'b0;
                ack_cnt_q <= 16'h0000;
            end else if (!port_wait_q && !port_access_i) begin
                ack_wait_q <= 1'b1;
                if (bit_tick_i && ack_cnt_q != `BYTE_TIME_BITS) begin
                    ack_cnt_q <= ack_cnt_q + 16'h0001;
                end
            end
            // port-access request: missing ack by the next access is a miss
            if (port_access_i) begin
                port_wait_q <= 1'b1;
            end else if (chan0_dma_acknowledge_i) begin
                port_wait_q <= 1'b0;
            end
        end
    end

    // data sync timeout counter in bit times
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dsync_cnt_q <= 16'h0000;
        end else if (!ev_i.wait_data_sync || ev_i.data_sync_seen) begin
            dsync_cnt_q <= 16'h0000;
        end else if (bit_tick_i && dsync_cnt_q != 16'hFFFF) begin
            dsync_cnt_q <= dsync_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // extended status
    // ------------------------------------------------------------------
    logic drive_overrun, micro_overrun, dsync_to;
    logic [15:0] dsync_limit;
    assign drive_overrun = ack_wait_q && ack_cnt_q == `BYTE_TIME_BITS;
    assign micro_overrun = port_wait_q && port_access_i;
    assign dsync_limit = misc_q[`BIT_DSYNC_SHORT] ? `DSYNC_SHORT_BITS :
                         `DSYNC_LONG_BITS;
    assign dsync_to = misc_q[`BIT_DSYNC_TO_EN] && ev_i.cmd_read &&
                      ev_i.wait_data_sync && dsync_cnt_q >= dsync_limit;

    // sets applied after preset and clears so events are never lost
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_q <= 8'h00;
        end else begin
            if (ev_i.cmd_start) begin
                ext_q[2] <= 1'b0;
                ext_q[4] <= 1'b0;
                ext_q[5] <= 1'b1;
            end else if (ev_i.id_sync_ok && ev_i.id_byte_valid &&
                         ev_i.id_byte_idx == 3'd4) begin
                ext_q[5] <= 1'b0;
            end
            if (parity_en) begin
                if (drive_overrun || micro_overrun) begin
                    ext_q[0] <= 1'b1;
                end
                if (ev_i.mem_parity_err) begin
                    ext_q[1] <= 1'b1;
                end
            end else begin
                if (drive_overrun) begin
                    ext_q[0] <= 1'b1;
                end
                if (micro_overrun) begin
                    ext_q[1] <= 1'b1;
                end
            end
            if (ev_i.index_timeout) begin
                ext_q[2] <= 1'b1;
            end
            if (ev_i.cmd_rw && ev_i.id_match &&
                (flag_byte_mode ? fifth_q != 8'h00 :
                 id_q[2][7:4] != 4'h0)) begin
                ext_q[3] <= 1'b1;
            end
            if (dsync_to) begin
                ext_q[4] <= 1'b1;
            end
            if (sec_s[1] && !sec_d1) begin
                ext_q[6] <= 1'b1;
            end else if (req.rd && req.addr == `ADDR_EXT_STATUS) begin
                ext_q[6] <= 1'b0;
            end
            if (idx_s[1] && !idx_d1) begin
                ext_q[7] <= 1'b1;
            end else if (req.rd && req.addr == `ADDR_EXT_STATUS) begin
                ext_q[7] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // ID capture
    // ------------------------------------------------------------------
    // loaded on valid sync whatever the check result; byte 4 is fifth
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 4; i++) begin
                id_q[i] <= 8'h00;
            end
            fifth_q <= 8'h00;
        end else if (ev_i.id_sync_ok && ev_i.id_byte_valid) begin
            if (ev_i.id_byte_idx == 3'd4) begin
                fifth_q <= ev_i.id_byte;
            end else if (ev_i.id_byte_idx < 3'd4) begin
                id_q[ev_i.id_byte_idx[1:0]] <= ev_i.id_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_busy_fall;
        busy_q && !seq_q[0] && int_en;
    endsequence

    a_bank0_wrap: assert property (
        dma_ext_q[3] && wrapped(a0_q, ch0_addr_i) && !req.wr
        |=> bank0_q == $past(bank0_q) + 4'h1)
        else $error("bank 0 did not step on wrap");
    a_busy_follow: assert property (ev_i.busy |=> seq_q[0])
        else $error("busy bit not set");
    a_id_ecc_set: assert property (ev_i.id_ecc_err |=> seq_q[4])
        else $error("id check bit not set");
    a_id_cmp_flag: assert property (
        ev_i.id_match && !ev_i.id_mismatch && !cmd_preset |=> !seq_q[6])
        else $error("id compare bit not cleared");
    // summary bit checked on the read data the micro really sees
    a_ext_or_bit: assert property (
        status_rd |=> rdata_o[7] == |$past(ext_q[4:0]))
        else $error("extended summary wrong");
    a_preset_vals: assert property (
        cmd_preset && !ev_i.id_ecc_err && !ev_i.index_timeout &&
        !dsync_to |=> ext_q[5] && !ext_q[2] && !ext_q[4] && seq_q[5])
        else $error("command preset wrong");
    a_index_latch: assert property (idx_s[1] && !idx_d1 |=> ext_q[7])
        else $error("index pulse lost");
    // raised, then still high one cycle later unless a status read was taken
    a_int_raise: assert property (
        s_busy_fall |=> sequencer_interrupt_o ##1
        (sequencer_interrupt_o || $past(status_rd)))
        else $error("interrupt not raised");
    a_id_capture: assert property (
        ev_i.id_sync_ok && ev_i.id_byte_valid && ev_i.id_byte_idx == 3'd0
        |=> id_q[0] == $past(ev_i.id_byte))
        else $error("id byte not captured");
endmodule

// ===== tb/seq_far_side.sv
// Purpose: far side model: sequencer events, disk pins, channel 0 DMA
// Assumes: one bit time is two clocks; disk pins idle low between pulses
// Notes: ack delay in bit times is set by the bench per scenario
`timescale 1ns/100ps
module seq_far_side (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic dma_req_i,
    output seq_status_pkg::seq_event_t ev_o,
    output logic bit_tick_o,
    output logic dma_ack_o,
    output logic sector_pin_o,
    output logic index_pin_o
);
    seq_status_pkg::seq_event_t lv;
    int ack_delay = 1;
    int waited = 0;

    // --------------------------------------------------------------
    // idle levels and bit time
    // --------------------------------------------------------------
    initial begin
        ev_o = '0;
        lv = '0;
        sector_pin_o = 1'b0;
        index_pin_o = 1'b0;
    end
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            bit_tick_o <= 1'b0;
        else
            bit_tick_o <= !bit_tick_o;
    end

    // channel 0 answers a request after ack_delay bit times
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i || !dma_req_i) begin
            dma_ack_o <= 1'b0;
            waited <= 0;
        end else if (bit_tick_o) begin
            waited <= waited + 1;
            if (waited + 1 >= ack_delay)
                dma_ack_o <= 1'b1;
        end
    end

    // levels stand until changed; pulses last one clock on top of them
    task automatic set_levels(input seq_status_pkg::seq_event_t e);
        @(posedge clock_i);
        lv <= e;
        ev_o <= e;
    endtask
    task automatic pulse(input seq_status_pkg::seq_event_t e);
        @(posedge clock_i);
        ev_o <= seq_status_pkg::seq_event_t'(lv | e);
        @(posedge clock_i);
        ev_o <= lv;
    endtask

    // pulse off the clock grid, just over a clock wide
    task automatic disk_pulse(input bit idx);
        @(posedge clock_i);
        #13;
        if (idx)
            index_pin_o = 1'b1;
        else
            sector_pin_o = 1'b1;
        #50;
        index_pin_o = 1'b0;
        sector_pin_o = 1'b0;
    endtask
endmodule

// ===== tb/disk_sequencer_status_regs_bench.sv
// Purpose: self-checking bench of the sequencer status bank
// Assumes: register map and bit positions of the shared header
// Notes: reads note the expected byte; a monitor compares one cycle later
`timescale 1ns/100ps
`include "seq_status_map.svh"
module disk_sequencer_status_regs_bench;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] rdata;
    logic [3:0] state = 4'h0;
    logic [3:0] retry = 4'h0;
    logic [3:0] bank0, bank1;
    logic dma_req = 1'b0;
    logic port_acc = 1'b0;
    logic [15:0] a0 = 16'h0000;
    logic [15:0] a1 = 16'h0000;
    logic dma_ack, tick, sec_pin, idx_pin, irq;
    seq_status_pkg::seq_event_t ev, lv, e;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] expq[$];

    seq_far_side far_i (.clock_i(clock_i), .rstn_i(rstn_i),
        .dma_req_i(dma_req), .ev_o(ev), .bit_tick_o(tick),
        .dma_ack_o(dma_ack), .sector_pin_o(sec_pin), .index_pin_o(idx_pin));
    seq_status_regs seq_status_regs_i (.clock_i(clock_i), .rstn_i(rstn_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_strobe), .rd_i(rd_strobe),
        .rdata_o(rdata), .ev_i(ev), .seq_state_i(state),
        .retry_count_i(retry), .bit_tick_i(tick), .sector_pin_i(sec_pin),
        .index_pin_i(idx_pin), .chan0_dma_request_i(dma_req),
        .chan0_dma_acknowledge_i(dma_ack), .port_access_i(port_acc),
        .ch0_addr_i(a0), .ch1_addr_i(a1), .ch0_bank_o(bank0),
        .ch1_bank_o(bank1), .sequencer_interrupt_o(irq));

    // --------------------------------------------------------------
    // clock, checks and bus tasks
    // --------------------------------------------------------------
    initial begin
        forever #20 clock_i = !clock_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock_i);
        wr_strobe <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        expq.push_back(exp);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock_i);
        rd_strobe <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        rd_seen <= rd_strobe;
        if (rd_seen)
            chk({8'h00, rdata}, {8'h00, expq.pop_front()});
    end
    // five header bytes, head/flag byte carries the given flag nibble
    task automatic send_id(input logic [3:0] flag);
        logic [7:0] b [0:4];
        for (int k = 0; k < 5; k++) begin
            b[k] = 8'($urandom);
            if (k == 2)
                b[k] = {flag, b[k][3:0]};
            e = '0;
            e.id_byte_valid = 1'b1;
            e.id_byte_idx = 3'(k);
            e.id_byte = b[k];
            far_i.pulse(e);
        end
        for (int k = 0; k < 4; k++)
            reg_rd(8'(`ADDR_ID_HDR_BASE + k), b[k]);
        reg_rd(`ADDR_ID_FIFTH, b[4]);
    endtask
    task automatic fire_cmd();
        e = '0;
        e.cmd_start = 1'b1;
        far_i.pulse(e);
    endtask
    // two buffer port touches with no channel 0 answer between them
    task automatic poke_port();
        repeat (2) begin
            @(posedge clock_i);
            port_acc <= 1'b1;
            @(posedge clock_i);
            port_acc <= 1'b0;
        end
    endtask

    // watchdog sized well above the whole sequence
    initial begin
        repeat (4000) @(posedge clock_i);
        n_fail++;
        summarize();
    end

    initial begin
        void'($urandom(85578));
        repeat (12) @(posedge clock_i);
        rstn_i <= 1'b1;
        chk({7'h00, irq, bank1, bank0}, 16'h0000);
        reg_rd(8'h7F, 8'h00);
        $display("test reset done");
        lv = '0;
        lv.busy = 1'b1;
        lv.cmd_rw = 1'b1;
        lv.cmd_read = 1'b1;
        lv.id_sync_ok = 1'b1;
        far_i.set_levels(lv);
        fire_cmd();
        reg_rd(`ADDR_SEQ_STATUS, 8'h71);
        reg_rd(`ADDR_EXT_STATUS, 8'h20);
        send_id(4'h0);
        reg_rd(`ADDR_EXT_STATUS, 8'h00);
        e = '0;
        e.id_match = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_SEQ_STATUS, 8'h31);
        e = '0;
        e.data_ecc_err = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_SEQ_STATUS, 8'h33);
        lv.cmd_verify = 1'b1;
        far_i.set_levels(lv);
        e = '0;
        e.data_sync_err = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_SEQ_STATUS, 8'h3F);
        $display("test status bits done");
        send_id(4'h5);
        e = '0;
        e.id_match = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_EXT_STATUS, 8'h08);
        reg_rd(`ADDR_SEQ_STATUS, 8'hBF);
        e = '0;
        e.index_timeout = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_EXT_STATUS, 8'h0C);
        // short data sync timeout and interrupt enable share this write
        reg_wr(`ADDR_CTRL_MISC, 8'hC0);
        lv.wait_data_sync = 1'b1;
        far_i.set_levels(lv);
        repeat (56) @(posedge clock_i);
        reg_rd(`ADDR_EXT_STATUS, 8'h0C);
        repeat (12) @(posedge clock_i);
        reg_rd(`ADDR_EXT_STATUS, 8'h1C);
        lv.wait_data_sync = 1'b0;
        far_i.set_levels(lv);
        $display("test timeouts done");
        far_i.ack_delay = 2;
        dma_req <= 1'b1;
        for (int i = 0; i < 100 && dma_ack !== 1'b1; i++)
            @(posedge clock_i);
        dma_req <= 1'b0;
        reg_rd(`ADDR_EXT_STATUS, 8'h1C);
        far_i.ack_delay = 20;
        dma_req <= 1'b1;
        for (int i = 0; i < 100 && dma_ack !== 1'b1; i++)
            @(posedge clock_i);
        dma_req <= 1'b0;
        reg_rd(`ADDR_EXT_STATUS, 8'h1D);
        far_i.disk_pulse(1'b0);
        far_i.disk_pulse(1'b1);
        repeat (4) @(posedge clock_i);
        reg_rd(`ADDR_EXT_STATUS, 8'hDD);
        reg_rd(`ADDR_EXT_STATUS, 8'h1D);
        $display("test overrun and pins done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            state <= 4'($urandom);
            retry <= 4'($urandom);
            @(posedge clock_i);
            reg_rd(`ADDR_STATE_RETRY, {state, retry});
        end
        reg_wr(`ADDR_DMA_EXT_CTRL, 8'h08);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 3; s++) begin
                @(posedge clock_i);
                a0 <= 16'hFFFE + 16'(s);
                a1 <= 16'hFFFE + 16'(s);
            end
            repeat (2) @(posedge clock_i);
            chk({8'h00, bank1, bank0}, {8'h00, 4'(p), 4'(p + 1)});
            reg_wr(`ADDR_DMA_EXT_CTRL, 8'h88);
        end
        $display("test bank counters done");
        lv.busy = 1'b0;
        far_i.set_levels(lv);
        repeat (3) @(posedge clock_i);
        chk({15'h0000, irq}, 16'h0001);
        reg_rd(`ADDR_SEQ_STATUS, 8'hBE);
        repeat (2) @(posedge clock_i);
        chk({15'h0000, irq}, 16'h0000);
        lv.busy = 1'b1;
        far_i.set_levels(lv);
        fire_cmd();
        reg_rd(`ADDR_EXT_STATUS, 8'h29);
        reg_rd(`ADDR_SEQ_STATUS, 8'hF1);
        poke_port();
        reg_rd(`ADDR_EXT_STATUS, 8'h2B);
        $display("test interrupt and preset done");
        repeat (3) @(posedge clock_i);
        // second reset in mid-run; parity mode needs fresh low bits
        rstn_i <= 1'b0;
        @(posedge clock_i);
        chk({7'h00, irq, bank1, bank0}, 16'h0000);
        rstn_i <= 1'b1;
        reg_wr(`ADDR_CTRL_MISC, 8'h10);
        e = '0;
        e.id_ecc_err = 1'b1;
        e.id_sync_err = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_SEQ_STATUS, 8'h39);
        poke_port();
        reg_rd(`ADDR_EXT_STATUS, 8'h01);
        e = '0;
        e.mem_parity_err = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_EXT_STATUS, 8'h03);
        // abort leaves the sequencer status as it was
        e = '0;
        e.cmd_start = 1'b1;
        e.cmd_abort = 1'b1;
        far_i.pulse(e);
        reg_rd(`ADDR_SEQ_STATUS, 8'hB9);
        $display("test second reset done");
        repeat (3) @(posedge clock_i);
        summarize();
    end
endmodule
